// ==== rtl/ttc_top.v ====
// terminal test control: command registers, modes, memory switch, launch
//
// Contract
// RULE1: command names terminal, else last named
// RULE2: segment writes only in a test mode
// RULE3: or switching moves only low half
// RULE4: invert switching swaps both halves; code inverts only unswitched terminals, switched ones read one
// RULE5: switched terminal sees top address bit one
// RULE6: interval register drives terminal pins directly
// RULE7: transmit interval field accepts 0 to 127
// RULE8: terminal gap accepts 2 to 126
// RULE9: sync gap only 16,32,64,127
// RULE10: mismatch with receive copy blocks transmit
// RULE11: mode codes 0 normal,1 test1,2 test2
// RULE12: collision commands only in test mode 2
// RULE13: disable clears label, backplane, external launch
// RULE14: immediate launch sends next data set
// RULE15: label match launches next data set
// RULE16: label launch after 2 plus c bits
// RULE17: backplane launch after 1 plus c bits
// RULE18: backplane pulses while transmitting are ignored
// RULE19: external trigger launches next data set
// RULE20: alternate on drives alternate pin true
// RULE21: alternate off drives alternate pin false
// RULE22: test ram access only test mode, disabled
// RULE23: segment register four bits, reset zero
// RULE24: bit strobe delays, launch advances pointer
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "ttc_defs.vh"
module ttc_top
(
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // shared memory address top bit from each terminal ic
  input wire [2:0] shm_msb_in,
  output wire [2:0] shm_msb_out,
  // interval pins and receive copies, 21 bits per terminal
  output wire [62:0] ivl_pins,
  input wire [62:0] ivl_rx_copy,
  output wire [2:0] tx_allow,
  // alternate mode pins
  output wire [2:0] alt_mode,
  // label receive and triggers
  input wire [2:0] label_valid,
  input wire [47:0] label_rx,
  input wire [2:0] bp_trig_n,
  input wire [2:0] ext_trig,
  // test data transmit
  input wire [2:0] tx_busy,
  input wire [2:0] data_ready,
  output wire [2:0] tx_start,
  output wire [11:0] seg_out,
  output wire [23:0] rd_ptr,
  output wire [2:0] ram_access_ok
);

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  reg ack_r;
  reg [1:0] term_r;
  reg [31:0] arg_r;
  reg sw_invert_r;
  reg [2:0] switched_r;
  reg [7:0] bit_cnt_r;
  wire bit_stb;
  wire cmd_wr;
  wire [1:0] cmd_term;
  wire [3:0] cmd_op;
  wire [2:0] cmd_sel;

  // one wait state on every access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign cmd_wr = avs_write & ack_r & (avs_address == `TTC_REG_CMD);
  assign cmd_op = avs_writedata[3:0];
  // bit 8 flags an explicit terminal in bits 5:4
  assign cmd_term = (avs_writedata[8] && avs_writedata[5:4] != 2'h3) ?
                    avs_writedata[5:4] : term_r; // [RULE1]
  assign cmd_sel = (3'h1 << cmd_term);

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ack_r <= 1'b0;
      term_r <= 2'h0;
      arg_r <= 32'h0;
      sw_invert_r <= 1'b0;
      switched_r <= 3'h0;
    end
    else
    begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      if (cmd_wr)
        term_r <= cmd_term; // [RULE1]
      if (avs_write && ack_r && avs_address == `TTC_REG_ARG)
        arg_r <= avs_writedata;
      if (cmd_wr && cmd_op == `TTC_CMD_SWMODE)
        sw_invert_r <= arg_r[0];
      if (cmd_wr && cmd_op == `TTC_CMD_SWITCH)
        switched_r[cmd_term] <= arg_r[0];
    end
  end

  // ----------------------------------------
  // bit-time strobe
  // ----------------------------------------
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      bit_cnt_r <= 8'h0;
    else if (bit_cnt_r == (`TTC_BIT_DIV - 1))
      bit_cnt_r <= 8'h0;
    else
      bit_cnt_r <= bit_cnt_r + 8'h1;
  end
  assign bit_stb = (bit_cnt_r == (`TTC_BIT_DIV - 1)); // [RULE24]

  // ----------------------------------------
  // per-terminal logic
  // ----------------------------------------
  wire [1:0] mode_w [0:2];
  wire [3:0] seg_w [0:2];
  wire [20:0] ivl_w [0:2];
  wire [1:0] src_w [0:2];
  wire [2:0] en_w;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : term
      reg [1:0] mode_r;
      reg [3:0] seg_r;
      reg [6:0] ti_r;
      reg [6:0] tg_r;
      reg [6:0] sg_r;
      reg alt_r;
      reg en_r;
      reg [1:0] src_r;
      reg [15:0] label_r;
      reg [7:0] dly_r;
      reg [7:0] wait_r;
      reg pend_r;
      reg start_r;
      reg [7:0] ptr_r;
      reg bp_prev_r;
      wire me;
      wire tm2;
      wire bp_fall;
      wire lbl_hit;
      wire fire_now;
      wire ti_ok;
      wire tg_ok;
      wire sg_ok;

      assign me = cmd_wr & cmd_sel[g];
      assign tm2 = (mode_r == `TTC_MODE_TEST2);
      assign bp_fall = bp_prev_r & ~bp_trig_n[g];
      assign lbl_hit = label_valid[g] & (label_rx[g*16 +: 16] == label_r); // [RULE15]
      assign fire_now = me && tm2 && en_r && data_ready[g] &&
                        cmd_op == `TTC_CMD_KNOW; // [RULE14]
      assign ti_ok = (arg_r[6:0] <= `TTC_TI_MAX); // [RULE7]
      assign tg_ok = (arg_r[14:8] >= `TTC_TG_MIN) &&
                     (arg_r[14:8] <= `TTC_TG_MAX); // [RULE8]
      assign sg_ok = (arg_r[22:16] == `TTC_SG_A) || (arg_r[22:16] == `TTC_SG_B) ||
                     (arg_r[22:16] == `TTC_SG_C) || (arg_r[22:16] == `TTC_SG_D); // [RULE9]

      always @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          mode_r <= `TTC_MODE_NORMAL;
          seg_r <= 4'h0; // [RULE23]
          ti_r <= 7'h0;
          tg_r <= `TTC_TG_MIN;
          sg_r <= `TTC_SG_A;
          alt_r <= 1'b0;
          en_r <= 1'b0;
          src_r <= `TTC_SRC_NONE;
          label_r <= 16'h0;
          dly_r <= 8'h0;
          wait_r <= 8'h0;
          pend_r <= 1'b0;
          start_r <= 1'b0;
          ptr_r <= 8'h0;
          bp_prev_r <= 1'b1;
        end
        else
        begin
          bp_prev_r <= bp_trig_n[g];
          start_r <= 1'b0;
          if (me)
          begin
            case (cmd_op)
              `TTC_CMD_LOGIC:
                if (arg_r[1:0] != 2'h3)
                  mode_r <= arg_r[1:0]; // [RULE11]
              `TTC_CMD_SEG:
                if (mode_r != `TTC_MODE_NORMAL)
                  seg_r <= arg_r[3:0]; // [RULE2]
              `TTC_CMD_IVL:
                if (ti_ok && tg_ok && sg_ok)
                begin
                  ti_r <= arg_r[6:0];
                  tg_r <= arg_r[14:8];
                  sg_r <= arg_r[22:16];
                end
              `TTC_CMD_ALTON:
                alt_r <= 1'b1; // [RULE20]
              `TTC_CMD_ALTOFF:
                alt_r <= 1'b0; // [RULE21]
              `TTC_CMD_ENABLE:
                en_r <= 1'b1;
              `TTC_CMD_DISABLE:
                en_r <= 1'b0;
              `TTC_CMD_KDIS:
                if (tm2)
                  src_r <= `TTC_SRC_NONE; // [RULE12] [RULE13]
              `TTC_CMD_KLBL:
                if (tm2)
                begin
                  src_r <= `TTC_SRC_LABEL; // [RULE12]
                  label_r <= arg_r[15:0];
                  dly_r <= arg_r[23:16];
                end
              `TTC_CMD_KBP:
                if (tm2)
                begin
                  src_r <= `TTC_SRC_BP; // [RULE12]
                  dly_r <= arg_r[23:16];
                end
              `TTC_CMD_KEXT:
                if (tm2)
                  src_r <= `TTC_SRC_EXT; // [RULE12]
              default:
                ;
            endcase
          end
          if (!tm2)
            pend_r <= 1'b0;
          else if (fire_now)
          begin
            start_r <= 1'b1; // [RULE14]
            pend_r <= 1'b0;
          end
          else if (pend_r)
          begin
            if (bit_stb)
            begin
              if (wait_r <= 8'h1)
              begin
                pend_r <= 1'b0;
                start_r <= data_ready[g];
              end
              else
                wait_r <= wait_r - 8'h1;
            end
          end
          else if (en_r && !tx_busy[g] && data_ready[g])
          begin
            if (src_r == `TTC_SRC_LABEL && lbl_hit)
            begin
              pend_r <= 1'b1;
              wait_r <= dly_r + `TTC_LBL_OFS; // [RULE16]
            end
            else if (src_r == `TTC_SRC_BP && bp_fall)
            begin
              pend_r <= 1'b1; // [RULE18]
              wait_r <= dly_r + `TTC_BP_OFS; // [RULE17]
            end
            else if (src_r == `TTC_SRC_EXT && ext_trig[g])
              start_r <= 1'b1; // [RULE19]
          end
          if (start_r)
            ptr_r <= ptr_r + 8'h1; // [RULE24]
        end
      end

      assign ivl_pins[g*21 +: 21] = {sg_r, tg_r, ti_r}; // [RULE6]
      assign tx_allow[g] = (ivl_rx_copy[g*21 +: 21] == {sg_r, tg_r, ti_r}); // [RULE10]
      assign alt_mode[g] = alt_r;
      assign tx_start[g] = start_r;
      assign seg_out[g*4 +: 4] = seg_r;
      assign rd_ptr[g*8 +: 8] = ptr_r;
      assign ram_access_ok[g] = (mode_r != `TTC_MODE_NORMAL) & ~en_r; // [RULE22]
      // top address bit as the terminal ic sees it
      assign shm_msb_out[g] = switched_r[g] ? 1'b1 : // [RULE5]
                              (sw_invert_r ? ~shm_msb_in[g] : shm_msb_in[g]); // [RULE3] [RULE4]
      assign mode_w[g] = mode_r;
      assign seg_w[g] = seg_r;
      assign ivl_w[g] = {sg_r, tg_r, ti_r};
      assign src_w[g] = src_r;
      assign en_w[g] = en_r;
    end
  endgenerate

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      avs_readdata <= 32'h0;
    else if (avs_read && !ack_r)
    begin
      case (avs_address)
        `TTC_REG_ARG:
          avs_readdata <= arg_r;
        `TTC_REG_STAT:
          avs_readdata <= {8'h0, switched_r, sw_invert_r, term_r,
                           mode_w[term_r], seg_w[term_r], src_w[term_r],
                           en_w[term_r], tx_allow, tx_busy, 3'h0};
        `TTC_REG_IVL:
          avs_readdata <= {11'h0, ivl_w[term_r]};
        default:
          avs_readdata <= 32'h0;
      endcase
    end
  end

endmodule

// ==== rtl/ttc_defs.vh ====
// constants for the terminal test control block
`ifndef TTC_DEFS_VH
`define TTC_DEFS_VH
// register offsets (byte addresses)
`define TTC_REG_CMD 4'h0
`define TTC_REG_ARG 4'h4
`define TTC_REG_STAT 4'h8
`define TTC_REG_IVL 4'hC
// command codes
`define TTC_CMD_LOGIC 4'h1
`define TTC_CMD_SEG 4'h2
`define TTC_CMD_SWMODE 4'h3
`define TTC_CMD_IVL 4'h4
`define TTC_CMD_KDIS 4'h5
`define TTC_CMD_KNOW 4'h6
`define TTC_CMD_KLBL 4'h7
`define TTC_CMD_KBP 4'h8
`define TTC_CMD_KEXT 4'h9
`define TTC_CMD_ALTON 4'hA
`define TTC_CMD_ALTOFF 4'hB
`define TTC_CMD_ENABLE 4'hC
`define TTC_CMD_DISABLE 4'hD
`define TTC_CMD_SWITCH 4'hE
// logic modes
`define TTC_MODE_NORMAL 2'h0
`define TTC_MODE_TEST1 2'h1
`define TTC_MODE_TEST2 2'h2
// launch sources
`define TTC_SRC_NONE 2'h0
`define TTC_SRC_LABEL 2'h1
`define TTC_SRC_BP 2'h2
`define TTC_SRC_EXT 2'h3
// interval field limits
`define TTC_TI_MAX 7'h7F
`define TTC_TG_MIN 7'h02
`define TTC_TG_MAX 7'h7E
`define TTC_SG_A 7'h10
`define TTC_SG_B 7'h20
`define TTC_SG_C 7'h40
`define TTC_SG_D 7'h7F
// fixed launch offsets in bit times
`define TTC_LBL_OFS 8'h02
`define TTC_BP_OFS 8'h01
// clock and bit rate
`define TTC_CLK_HZ 200000000
`define TTC_BIT_HZ 2000000
`define TTC_BIT_DIV (`TTC_CLK_HZ / `TTC_BIT_HZ)
`endif

// ==== verification/ttc_monitor.sv ====
// concurrent checks on the terminal test control ports
`timescale 1ns/1ps
module ttc_monitor
(
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  // bus handshake
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // terminal side
  input wire [11:0] seg_out,
  input wire [62:0] ivl_pins,
  input wire [62:0] ivl_rx_copy,
  input wire [2:0] tx_allow,
  input wire [2:0] tx_start,
  input wire [23:0] rd_ptr
);
  wire req = avs_read | avs_write;
  wire taken = req & ~avs_waitrequest;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  a_one_wait: assert property ($rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus wait state count off");
  a_start_pulse: assert property (tx_start != 3'h0 |=> (tx_start & $past(tx_start)) == 3'h0)
    else $error("start pulse longer than one cycle");
  a_ptr_step: assert property (tx_start[0] |=> rd_ptr[7:0] == $past(rd_ptr[7:0]) + 8'h01)
    else $error("read pointer did not advance");
  a_allow_match: assert property (tx_allow == {ivl_pins[62:42] == ivl_rx_copy[62:42],
    ivl_pins[41:21] == ivl_rx_copy[41:21], ivl_pins[20:0] == ivl_rx_copy[20:0]})
    else $error("transmit allow wrong");
  a_seg_cause: assert property (!$stable(seg_out) |-> $past(taken) || $past(taken, 2))
    else $error("segment changed without command");
  a_ivl_cause: assert property (!$stable(ivl_pins) |-> $past(taken) || $past(taken, 2))
    else $error("interval pins changed without command");
  a_gap_range: assert property (ivl_pins[13:7] >= 7'h02 && ivl_pins[13:7] <= 7'h7E)
    else $error("terminal gap out of range");
  a_sync_set: assert property (ivl_pins[20:14] inside {7'h10, 7'h20, 7'h40, 7'h7F})
    else $error("sync gap not allowed");
endmodule
bind ttc_top ttc_monitor i_ttc_monitor (.ref_clk, .resetn, .avs_read, .avs_write,
  .avs_waitrequest, .seg_out, .ivl_pins, .ivl_rx_copy, .tx_allow, .tx_start, .rd_ptr);

// ==== verification/ttc_term_model.sv ====
// terminal ic stand-in: busy after each start, receive copy of interval pins
`timescale 1ns/1ps
module ttc_term_model
#(
  parameter BUSY_CYC = 400
)
(
  // clock and reset
  input wire ref_clk,
  input wire resetn,
  // from the block and the bench
  input wire [2:0] tx_start,
  input wire [62:0] ivl_pins,
  input wire [2:0] copy_load,
  // to the block
  output wire [2:0] tx_busy,
  output reg [62:0] ivl_rx_copy,
  output wire [2:0] data_ready
);
  integer cnt [0:2];
  integer g;
  assign data_ready = 3'h7;
  always @(posedge ref_clk or negedge resetn)
  begin
    for (g = 0; g < 3; g = g + 1)
    begin
      if (!resetn)
        cnt[g] <= 0;
      else if (tx_start[g])
        cnt[g] <= BUSY_CYC;
      else if (cnt[g] != 0)
        cnt[g] <= cnt[g] - 1;
      if (!resetn)
        ivl_rx_copy[g*21 +: 21] <= 21'h0;
      else if (copy_load[g])
        ivl_rx_copy[g*21 +: 21] <= ivl_pins[g*21 +: 21];
    end
  end
  assign tx_busy = {cnt[2] != 0, cnt[1] != 0, cnt[0] != 0};
endmodule

// ==== verification/ttc_top_tb.sv ====
// self-checking bench for the terminal test control block
`timescale 1ns/1ps
`include "ttc_defs.vh"
module ttc_top_tb;
  reg ref_clk = 1'h0;
  reg resetn = 1'h0;
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'h0;
  reg avs_write = 1'h0;
  reg [31:0] avs_writedata = 32'h0;
  reg [2:0] shm_msb_in = 3'h0;
  reg [2:0] label_valid = 3'h0;
  reg [47:0] label_rx = 48'h0;
  reg [2:0] bp_trig_n = 3'h7;
  reg [2:0] ext_trig = 3'h0;
  reg [2:0] copy_load = 3'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [2:0] shm_msb_out, tx_allow, alt_mode, tx_busy, data_ready, tx_start, ram_access_ok;
  wire [62:0] ivl_pins, ivl_rx_copy;
  wire [11:0] seg_out;
  wire [23:0] rd_ptr;
  integer mismatches = 0, n_compared = 0, seed = 36222, m, p;
  reg [6:0] ti;
  reg [31:0] rq_exp[$], rq_msk[$];
  reg [2:0] sq[$];
  always #2.5 ref_clk = ~ref_clk;
  ttc_top i_ttc_top (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .shm_msb_in(shm_msb_in), .shm_msb_out(shm_msb_out), .ivl_pins(ivl_pins),
    .ivl_rx_copy(ivl_rx_copy), .tx_allow(tx_allow), .alt_mode(alt_mode),
    .label_valid(label_valid), .label_rx(label_rx), .bp_trig_n(bp_trig_n),
    .ext_trig(ext_trig), .tx_busy(tx_busy), .data_ready(data_ready), .tx_start(tx_start),
    .seg_out(seg_out), .rd_ptr(rd_ptr), .ram_access_ok(ram_access_ok));
  ttc_term_model #(.BUSY_CYC(400)) i_ttc_term_model (.ref_clk(ref_clk), .resetn(resetn),
    .tx_start(tx_start), .ivl_pins(ivl_pins), .copy_load(copy_load), .tx_busy(tx_busy),
    .ivl_rx_copy(ivl_rx_copy), .data_ready(data_ready));
  task summarize;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // ----------------------------------------
  // bus access, one request held until taken
  // ----------------------------------------
  task bus(input w, input [3:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      k = 0;
      @(negedge ref_clk);
      while (avs_waitrequest !== 1'h0 && k < 50)
      begin
        @(negedge ref_clk);
        k = k + 1;
      end
      @(posedge ref_clk);
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      if (k >= 50)
        chk(k, 0);
      if (k >= 50)
        summarize;
    end
  endtask
  task rd(input [3:0] a, input [31:0] e, input [31:0] msk);
    begin
      rq_exp.push_back(e);
      rq_msk.push_back(msk);
      bus(1'h0, a, 32'h0);
    end
  endtask
  // terminal 3 means none named
  task cmd(input [3:0] op, input [1:0] t, input [31:0] arg);
    begin
      bus(1'h1, `TTC_REG_ARG, arg);
      bus(1'h1, `TTC_REG_CMD, {23'h0, t != 2'h3, 2'h0, t, op});
      repeat (3) @(negedge ref_clk);
    end
  endtask
  task wst(input integer lo, input integer hi);
    integer n;
    begin
      n = 0;
      @(negedge ref_clk);
      while (tx_start[0] !== 1'h1 && n <= hi)
      begin
        @(negedge ref_clk);
        n = n + 1;
      end
      chk(n >= lo && n <= hi, 1);
      if (n > hi)
        summarize;
    end
  endtask
  always @(negedge ref_clk)
  begin
    if (avs_read && avs_waitrequest === 1'h0)
      chk(avs_readdata & rq_msk.pop_front(), rq_exp.pop_front());
    if (resetn && tx_start !== 3'h0)
      chk(tx_start, sq.size() ? sq.pop_front() : 3'h0);
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'h1;
    rd(`TTC_REG_IVL, 32'h40100, 32'h1FFFFF);
    chk(seg_out, 0);
    cmd(`TTC_CMD_SEG, 0, 5);
    chk(seg_out, 0);
    for (m = 0; m < 3; m = m + 1)
    begin
      cmd(`TTC_CMD_LOGIC, 1, m);
      rd(`TTC_REG_STAT, {12'h0, 2'h1, m[1:0], 16'h0}, 32'h000F0000);
    end
    cmd(`TTC_CMD_SEG, 3, 15);
    chk(seg_out[7:4], 4'hF);
    cmd(`TTC_CMD_LOGIC, 0, 1);
    cmd(`TTC_CMD_SEG, 0, 5);
    chk(seg_out[3:0], 4'h5);
    m = $random(seed);
    ti = m[6:0];
    cmd(`TTC_CMD_IVL, 0, {9'h0, 7'h20, 1'h0, 7'h7E, 1'h0, ti});
    chk(ivl_pins[20:0], {7'h20, 7'h7E, ti});
    cmd(`TTC_CMD_IVL, 0, {9'h0, 7'h40, 1'h0, 7'h01, 1'h0, ti});
    cmd(`TTC_CMD_IVL, 0, {9'h0, 7'h11, 1'h0, 7'h05, 1'h0, ti});
    chk(ivl_pins[20:0], {7'h20, 7'h7E, ti});
    @(posedge ref_clk);
    copy_load <= 3'h1;
    @(posedge ref_clk);
    copy_load <= 3'h0;
    repeat (2) @(negedge ref_clk);
    chk(tx_allow[0], 1);
    cmd(`TTC_CMD_IVL, 0, {9'h0, 7'h7F, 1'h0, 7'h02, 1'h0, ti});
    chk(tx_allow[0], 0);
    cmd(`TTC_CMD_ALTON, 2, 0);
    chk(alt_mode, 4);
    cmd(`TTC_CMD_ALTOFF, 3, 0);
    chk(alt_mode, 0);
    @(posedge ref_clk);
    m = $random(seed);
    shm_msb_in <= m[2:0];
    cmd(`TTC_CMD_SWMODE, 0, 0);
    cmd(`TTC_CMD_SWITCH, 0, 1);
    chk(shm_msb_out[1:0], {shm_msb_in[1], 1'h1});
    cmd(`TTC_CMD_SWMODE, 0, 1);
    chk(shm_msb_out[0], 1);
    cmd(`TTC_CMD_SWMODE, 0, 0);
    cmd(`TTC_CMD_SWITCH, 0, 0);
    chk(shm_msb_out, shm_msb_in);
    cmd(`TTC_CMD_KNOW, 0, 0);
    chk(ram_access_ok[0], 1);
    cmd(`TTC_CMD_LOGIC, 0, 2);
    cmd(`TTC_CMD_ENABLE, 0, 0);
    chk(ram_access_ok[0], 0);
    p = rd_ptr[7:0];
    sq.push_back(3'h1);
    cmd(`TTC_CMD_KNOW, 0, 0);
    chk(rd_ptr[7:0], p + 1);
    repeat (420) @(negedge ref_clk);
    cmd(`TTC_CMD_KLBL, 0, {8'h0, 8'h03, 16'h5034});
    for (m = 0; m < 2; m = m + 1)
    begin
      if (m)
        sq.push_back(3'h1);
      @(posedge ref_clk);
      label_rx <= {32'h0, 16'h5035 - m[15:0]};
      label_valid <= 3'h1;
      @(posedge ref_clk);
      label_valid <= 3'h0;
      if (m)
        wst(400, 505);
      else
        repeat (600) @(negedge ref_clk);
    end
    repeat (420) @(negedge ref_clk);
    cmd(`TTC_CMD_KBP, 0, {8'h0, 8'h02, 16'h0});
    sq.push_back(3'h1);
    @(posedge ref_clk);
    bp_trig_n <= 3'h6;
    wst(200, 304);
    @(posedge ref_clk);
    bp_trig_n <= 3'h7;
    @(posedge ref_clk);
    bp_trig_n <= 3'h6;
    repeat (600) @(negedge ref_clk);
    cmd(`TTC_CMD_KDIS, 0, 0);
    @(posedge ref_clk);
    bp_trig_n <= 3'h7;
    @(posedge ref_clk);
    bp_trig_n <= 3'h6;
    repeat (400) @(negedge ref_clk);
    cmd(`TTC_CMD_KEXT, 0, 0);
    sq.push_back(3'h1);
    @(posedge ref_clk);
    ext_trig <= 3'h1;
    @(posedge ref_clk);
    ext_trig <= 3'h0;
    wst(0, 3);
    repeat (20) @(negedge ref_clk);
    chk(sq.size(), 0);
    summarize;
  end
endmodule
